/* File: include/fed_pkg.sv */
`default_nettype none
package fed_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CSR    = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // control/status word layout
    localparam int RM_LSB    = 0;
    localparam int FLAG_LSB  = 2;
    localparam int EN_LSB    = 7;
    localparam int CAUSE_LSB = 12;
    localparam int FS_BIT    = 24;
    localparam int ISA2_BIT  = 25;
    // status word layout
    localparam int ST_PEND_LSB  = 0;
    localparam int ST_PENDV_BIT = 8;

    localparam logic [1:0] RESET_RM    = 2'h0;
    localparam logic [4:0] RESET_FLAGS = 5'h00;
    localparam logic [4:0] RESET_EN    = 5'h00;
    localparam logic [5:0] RESET_CAUSE = 6'h00;

    // ----------------------------------------------------------------
    // cause bit positions
    // ----------------------------------------------------------------
    localparam int C_INEXACT   = 0;
    localparam int C_UNDERFLOW = 1;
    localparam int C_OVERFLOW  = 2;
    localparam int C_DIVZERO   = 3;
    localparam int C_INVALID   = 4;
    localparam int C_UNIMPL    = 5;

    // exponent window outside which an operand may lead to a trap
    localparam logic [10:0] RISK_EXP_HI = 11'h7F0;
    localparam logic [10:0] RISK_EXP_LO = 11'h00F;

    typedef enum logic [1:0] {
        round_nearest     = 2'b00,
        round_toward_zero = 2'b01,
        round_up          = 2'b10,
        round_down        = 2'b11
    } fed_rmode_t;

    typedef enum logic [3:0] {
        OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MUL = 4'h2, OP_DIV = 4'h3,
        OP_SQRT = 4'h4, absolute_value_op = 4'h5, negate_op = 4'h6,
        register_move_op = 4'h7, OP_CMP = 4'h8, OP_F2W = 4'h9,
        OP_F2L = 4'hA, OP_L2F = 4'hB, format_convert_op = 4'hC,
        OP_RSVD = 4'hF
    } fed_op_t;

    typedef enum logic [2:0] {
        CL_ZERO = 3'h0, CL_NORM = 3'h1, CL_DENORM = 3'h2,
        CL_INF = 3'h3, CL_QNAN = 3'h4, CL_SNAN = 3'h5
    } fed_class_t;

    typedef enum logic [2:0] {
        WB_ROUNDED = 3'h0, WB_QNAN = 3'h1, WB_INF = 3'h2,
        WB_MAXFIN = 3'h3, WB_MINFIN = 3'h4, WB_ZERO = 3'h5
    } fed_wbsel_t;
endpackage : fed_pkg
`default_nettype wire

/* File: logic/fed_exception_unit.sv */
// How it works
// RULE1 - inexact raised when rounded result differs from exact or overflows
// RULE2 - underflow raises inexact only with both enables clear and flush set
// RULE3 - operand exponents inspected before execution; possible traps run stalled
// RULE4 - inexact traps enabled: every multicycle operation runs stalled
// RULE5 - inexact trapped keeps destination; untrapped writes rounded value
// RULE6 - invalid on inf minus inf, zero times inf, 0/0, inf/inf, sqrt negative
// RULE7 - ordered compare of unordered, compare or convert of signaling NaN invalid
// RULE8 - signaling NaN in arithmetic incl. abs and negate invalid; move never
// RULE9 - untrapped invalid writes quiet NaN; trapped leaves operands alone
// RULE10 - divide by zero of finite nonzero dividend raises divide-by-zero
// RULE11 - untrapped divide-by-zero writes signed infinity; trapped keeps destination
// RULE12 - overflow when rounded magnitude exceeds largest finite; also sets inexact
// RULE13 - trapped overflow keeps destination; untrapped result from mode and sign
// RULE14 - tininess is detected after rounding
// RULE15 - loss of accuracy for underflow judged as inexact result; code takes any tiny result as underflow, exact or not
// RULE16 - underflow with u or i enabled or flush clear raises unimplemented
// RULE17 - underflow with traps off and flush set delivers mode-chosen result
// RULE18 - reserved operation or format sets unimplemented and traps
// RULE19 - denormal or quiet NaN operands unimplemented only for compute or convert
// RULE20 - unimplemented: bad format op, f2i overflow, long range, sqrt in isa2
// RULE21 - long to float unimplemented only when bits 63:55 not uniform
// RULE22 - unimplemented cannot be disabled; operands stay undisturbed
// RULE23 - cause always set; flag when enable clear, else trap request
// RULE24 - untrapped underflow result: zero or smallest finite per rounding mode
// RULE25 - untrapped overflow result: infinity or largest finite per rounding mode
// RULE26 - one trap request per instruction; cause holds all its exceptions
`timescale 1ns/100ps
`default_nettype none
module fed_exception_unit (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // instruction check before execution
    input  wire logic        issue_valid_in,
    input  wire logic [3:0]  issue_op_in,
    input  wire logic        issue_fmt_rsvd_in,
    input  wire logic        issue_fmt_same_in,
    input  wire logic        issue_multi_in,
    input  wire logic        issue_cmp_ordered_in,
    input  wire logic [2:0]  issue_a_class_in,
    input  wire logic [2:0]  issue_b_class_in,
    input  wire logic        issue_a_sign_in,
    input  wire logic        issue_b_sign_in,
    input  wire logic [10:0] issue_a_exp_in,
    input  wire logic [10:0] issue_b_exp_in,
    input  wire logic [8:0]  issue_int_hi_in,
    // result check after execution
    input  wire logic        res_valid_in,
    input  wire logic        res_inexact_in,
    input  wire logic        res_overflow_in,
    input  wire logic        res_tiny_in,
    input  wire logic        res_sign_in,
    input  wire logic        res_int_ovf_in,
    input  wire logic        res_long_range_in,
    // response to the pipeline
    output logic             stall_req_out,
    output logic             trap_req_out,
    output logic             wb_en_out,
    output logic      [2:0]  wb_sel_out,
    output logic             wb_sign_out,
    output logic      [5:0]  cause_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  rm;
        logic [4:0]  flags;
        logic [4:0]  en;
        logic [5:0]  cause;
        logic        fs;
        logic        isa2;
        logic [5:0]  pend;
        logic        pend_v;
        logic        wr_pend;
        logic [7:0]  waddr;
        logic [31:0] rdata;
        logic        stall;
        logic        trap;
        logic        wb_en;
        logic [2:0]  wb_sel;
        logic        wb_sign;
    } fed_state_t;

    fed_state_t q;
    fed_state_t d;

    // ----------------------------------------------------------------
    // operand decode
    // ----------------------------------------------------------------
    fed_pkg::fed_op_t    op;
    fed_pkg::fed_class_t ca;
    fed_pkg::fed_class_t cb;
    assign op = fed_pkg::fed_op_t'(issue_op_in);
    assign ca = fed_pkg::fed_class_t'(issue_a_class_in);
    assign cb = fed_pkg::fed_class_t'(issue_b_class_in);

    logic is_arith;
    logic is_cvt;
    logic any_snan;
    logic any_nan;
    logic any_dq;
    logic inf_sub;
    logic risk_a;
    logic risk_b;
    logic pre_inv;
    logic pre_dz;
    logic pre_unimpl;
    logic pre_risk;
    logic [5:0] pre_c;

    assign is_cvt = (op == fed_pkg::OP_F2W) || (op == fed_pkg::OP_F2L)
                 || (op == fed_pkg::OP_L2F) || (op == fed_pkg::format_convert_op);
    // abs and negate are arithmetic here, a plain move is not
    assign is_arith = (op != fed_pkg::register_move_op) && (op != fed_pkg::OP_CMP)
                   && (op != fed_pkg::OP_RSVD); // RULE8
    assign any_snan = (ca == fed_pkg::CL_SNAN) || (cb == fed_pkg::CL_SNAN);
    assign any_nan  = any_snan || (ca == fed_pkg::CL_QNAN) || (cb == fed_pkg::CL_QNAN);
    assign any_dq   = (ca == fed_pkg::CL_DENORM) || (cb == fed_pkg::CL_DENORM)
                   || (ca == fed_pkg::CL_QNAN) || (cb == fed_pkg::CL_QNAN);
    // magnitude subtraction of two infinities
    assign inf_sub  = (ca == fed_pkg::CL_INF) && (cb == fed_pkg::CL_INF)
                   && (((op == fed_pkg::OP_ADD) && (issue_a_sign_in != issue_b_sign_in))
                    || ((op == fed_pkg::OP_SUB) && (issue_a_sign_in == issue_b_sign_in)));

    assign pre_inv =
        inf_sub
        || ((op == fed_pkg::OP_MUL) && (((ca == fed_pkg::CL_ZERO) && (cb == fed_pkg::CL_INF))
            || ((ca == fed_pkg::CL_INF) && (cb == fed_pkg::CL_ZERO))))
        || ((op == fed_pkg::OP_DIV) && (ca == cb)
            && ((ca == fed_pkg::CL_ZERO) || (ca == fed_pkg::CL_INF)))
        || ((op == fed_pkg::OP_SQRT) && issue_a_sign_in
            && (ca != fed_pkg::CL_ZERO) && !any_nan)                       // RULE6
        || ((op == fed_pkg::OP_CMP) && issue_cmp_ordered_in && any_nan)
        || (((op == fed_pkg::OP_CMP) || (op == fed_pkg::OP_F2W)
            || (op == fed_pkg::OP_F2L)) && any_snan)                       // RULE7
        || (is_arith && any_snan);                                         // RULE8

    assign pre_dz = (op == fed_pkg::OP_DIV) && (cb == fed_pkg::CL_ZERO)
                 && ((ca == fed_pkg::CL_NORM) || (ca == fed_pkg::CL_DENORM)); // RULE10

    assign pre_unimpl =
        (op == fed_pkg::OP_RSVD) || issue_fmt_rsvd_in                       // RULE18
        || (is_arith && (op != fed_pkg::absolute_value_op)
            && (op != fed_pkg::negate_op) && any_dq)                        // RULE19
        || ((op == fed_pkg::format_convert_op) && issue_fmt_same_in)
        || ((op == fed_pkg::OP_SQRT) && q.isa2)                             // RULE20
        || ((op == fed_pkg::OP_L2F)
            && (issue_int_hi_in != 9'h000) && (issue_int_hi_in != 9'h1FF)); // RULE21

    // only normal operands have a meaningful exponent to inspect
    assign risk_a = (ca == fed_pkg::CL_NORM) && ((issue_a_exp_in >= fed_pkg::RISK_EXP_HI)
                 || (issue_a_exp_in <= fed_pkg::RISK_EXP_LO));
    assign risk_b = (cb == fed_pkg::CL_NORM) && ((issue_b_exp_in >= fed_pkg::RISK_EXP_HI)
                 || (issue_b_exp_in <= fed_pkg::RISK_EXP_LO));
    assign pre_risk = is_arith && (risk_a || risk_b);                     // RULE3

    always_comb begin
        pre_c = 6'h00;
        pre_c[fed_pkg::C_INVALID] = pre_inv;
        pre_c[fed_pkg::C_DIVZERO] = pre_dz;
        pre_c[fed_pkg::C_UNIMPL]  = pre_unimpl;
    end

    // ----------------------------------------------------------------
    // result evaluation
    // ----------------------------------------------------------------
    logic       unf_e;
    logic       unf_ok;
    logic [5:0] res_c;
    logic       res_trap;
    logic [2:0] res_sel;

    // tiny after rounding is underflow, whether the delivery is exact or inexact
    assign unf_e  = res_tiny_in && (q.en[fed_pkg::C_UNDERFLOW] || q.en[fed_pkg::C_INEXACT]
                 || !q.fs);                                               // RULE16
    assign unf_ok = res_tiny_in && !unf_e;                                // RULE14 RULE15

    always_comb begin
        res_c = q.pend;
        res_c[fed_pkg::C_OVERFLOW]  = res_overflow_in;                     // RULE12
        res_c[fed_pkg::C_INEXACT]   = res_overflow_in                      // RULE1
                                   || (res_inexact_in && !res_tiny_in)
                                   || unf_ok;                              // RULE2
        res_c[fed_pkg::C_UNDERFLOW] = unf_ok;                              // RULE17
        res_c[fed_pkg::C_UNIMPL]    = q.pend[fed_pkg::C_UNIMPL] || unf_e
                                   || res_int_ovf_in || res_long_range_in; // RULE20
    end

    // unimplemented has no enable and always traps
    assign res_trap = res_c[fed_pkg::C_UNIMPL] || ((res_c[4:0] & q.en) != 5'h00); // RULE22

    always_comb begin
        res_sel = fed_pkg::WB_ROUNDED;
        if (res_c[fed_pkg::C_INVALID]) begin
            res_sel = fed_pkg::WB_QNAN;                                    // RULE9
        end else if (res_c[fed_pkg::C_DIVZERO]) begin
            res_sel = fed_pkg::WB_INF;                                     // RULE11
        end else if (res_c[fed_pkg::C_OVERFLOW]) begin
            unique case (fed_pkg::fed_rmode_t'(q.rm))                      // RULE25
                fed_pkg::round_nearest:     res_sel = fed_pkg::WB_INF;
                fed_pkg::round_toward_zero: res_sel = fed_pkg::WB_MAXFIN;
                fed_pkg::round_up:
                    res_sel = res_sign_in ? fed_pkg::WB_MAXFIN : fed_pkg::WB_INF;
                fed_pkg::round_down:
                    res_sel = res_sign_in ? fed_pkg::WB_INF : fed_pkg::WB_MAXFIN;
            endcase
        end else if (res_c[fed_pkg::C_UNDERFLOW]) begin
            unique case (fed_pkg::fed_rmode_t'(q.rm))                      // RULE24
                fed_pkg::round_nearest:     res_sel = fed_pkg::WB_ZERO;
                fed_pkg::round_toward_zero: res_sel = fed_pkg::WB_ZERO;
                fed_pkg::round_up:
                    res_sel = res_sign_in ? fed_pkg::WB_ZERO : fed_pkg::WB_MINFIN;
                fed_pkg::round_down:
                    res_sel = res_sign_in ? fed_pkg::WB_MINFIN : fed_pkg::WB_ZERO;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic ahb_go;
    assign ahb_go = hsel_in && htrans_in[1] && hready_in;

    always_comb begin
        d         = q;
        d.stall   = 1'b0;
        d.trap    = 1'b0;
        d.wb_en   = 1'b0;
        // register write lands in the data phase
        if (q.wr_pend && (q.waddr == fed_pkg::ADDR_CSR)) begin
            d.rm    = hwdata_in[fed_pkg::RM_LSB +: 2];
            d.flags = hwdata_in[fed_pkg::FLAG_LSB +: 5];
            d.en    = hwdata_in[fed_pkg::EN_LSB +: 5];
            d.cause = hwdata_in[fed_pkg::CAUSE_LSB +: 6];
            d.fs    = hwdata_in[fed_pkg::FS_BIT];
            d.isa2  = hwdata_in[fed_pkg::ISA2_BIT];
        end
        d.wr_pend = ahb_go && hwrite_in;
        d.waddr   = haddr_in[7:0];
        // the result closes the held instruction before a new one opens
        if (res_valid_in) begin
            d.cause   = res_c;                                             // RULE26
            // hardware set wins over a software clear in the same cycle
            d.flags   = d.flags | (res_c[4:0] & ~q.en);                    // RULE23
            d.trap    = res_trap;                                          // RULE23
            d.wb_en   = !res_trap;                      // RULE5 RULE13 RULE22
            d.wb_sel  = res_sel;
            d.wb_sign = res_sign_in;
            d.pend    = 6'h00;
            d.pend_v  = 1'b0;
        end
        if (issue_valid_in) begin
            d.pend   = pre_c;
            d.pend_v = 1'b1;
            d.stall  = (pre_c != 6'h00) || pre_risk
                    || (q.en[fed_pkg::C_INEXACT] && issue_multi_in);       // RULE3 RULE4
        end
        // read data is taken from the updated state so a write is seen at once
        if (ahb_go && !hwrite_in) begin
            d.rdata = 32'h0000_0000;
            if (haddr_in[7:0] == fed_pkg::ADDR_CSR) begin
                d.rdata[fed_pkg::RM_LSB +: 2]    = d.rm;
                d.rdata[fed_pkg::FLAG_LSB +: 5]  = d.flags;
                d.rdata[fed_pkg::EN_LSB +: 5]    = d.en;
                d.rdata[fed_pkg::CAUSE_LSB +: 6] = d.cause;
                d.rdata[fed_pkg::FS_BIT]         = d.fs;
                d.rdata[fed_pkg::ISA2_BIT]       = d.isa2;
            end else if (haddr_in[7:0] == fed_pkg::ADDR_STATUS) begin
                d.rdata[fed_pkg::ST_PEND_LSB +: 6] = d.pend;
                d.rdata[fed_pkg::ST_PENDV_BIT]     = d.pend_v;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q         <= '0;
            q.rm      <= fed_pkg::RESET_RM;
            q.flags   <= fed_pkg::RESET_FLAGS;
            q.en      <= fed_pkg::RESET_EN;
            q.cause   <= fed_pkg::RESET_CAUSE;
            q.wb_sel  <= fed_pkg::WB_ROUNDED;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata_out    = q.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign stall_req_out = q.stall;
    assign trap_req_out  = q.trap;
    assign wb_en_out     = q.wb_en;
    assign wb_sel_out    = q.wb_sel;
    assign wb_sign_out   = q.wb_sign;
    assign cause_out     = q.cause;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_ovf_sets_inexact: assert property ( // RULE1
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_in && res_overflow_in |=> cause_out[0] && cause_out[2])
        else $error("overflow did not set inexact and overflow cause");

    a_flush_unf_inexact: assert property ( // RULE2
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_in && res_tiny_in && q.fs && (q.en[1:0] == 2'b00)
        |=> cause_out[0] && cause_out[1] && !cause_out[5])
        else $error("flushed underflow did not raise inexact");

    a_inexact_stall: assert property ( // RULE4
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        issue_valid_in && issue_multi_in && q.en[0] |=> stall_req_out)
        else $error("multicycle op not stalled with inexact trap on");

    a_move_no_invalid: assert property ( // RULE8
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        issue_valid_in && (issue_op_in == 4'h7) |=> !q.pend[4])
        else $error("register move raised invalid");

    a_divzero_detect: assert property ( // RULE10
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        issue_valid_in && (issue_op_in == 4'h3) && (issue_b_class_in == 3'h0)
        && (issue_a_class_in == 3'h1) |=> q.pend[3] && stall_req_out)
        else $error("divide by zero not detected");

    a_unf_unimpl_trap: assert property ( // RULE16
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_in && res_tiny_in && !q.fs
        |=> trap_req_out && !wb_en_out && cause_out[5])
        else $error("underflow without flush did not trap unimplemented");

    a_flag_or_trap: assert property ( // RULE23
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_in |=> ((cause_out[4:0] & ~$past(q.en) & ~q.flags) == 5'h00)
        && (trap_req_out == (cause_out[5] || ((cause_out[4:0] & $past(q.en)) != 5'h00))))
        else $error("flag or trap does not follow cause and enable");

    a_ovf_nearest_inf: assert property ( // RULE25
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_in && res_overflow_in && (q.rm == 2'b00) && (q.pend == 6'h00)
        && (q.en == 5'h00) |=> wb_en_out && (wb_sel_out == 3'h2))
        else $error("untrapped overflow in nearest mode not infinity");

    a_invalid_qnan: assert property ( // RULE9
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_in && q.pend[4] && !res_trap |=> wb_en_out && (wb_sel_out == 3'h1))
        else $error("untrapped invalid did not deliver a quiet nan");

    a_unimpl_traps: assert property ( // RULE22
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_in && (q.pend[5] || res_int_ovf_in || res_long_range_in)
        |=> trap_req_out && !wb_en_out && cause_out[5])
        else $error("unimplemented operation did not trap");

    a_one_answer: assert property ( // RULE26
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(trap_req_out) |-> !wb_en_out && $past(res_valid_in))
        else $error("trap request not tied to a single result");
endmodule : fed_exception_unit
`default_nettype wire

/* File: dv/fed_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// cpu exception logic: counts trap requests taken
// ------------------------------------------------
module fed_cpu_model (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       trap_in,
    output logic      [7:0] traps_out
);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            traps_out <= 8'h00;
        else if (trap_in)
            traps_out <= traps_out + 8'h01;
    end
endmodule : fed_cpu_model
`default_nettype wire

/* File: dv/fed_exception_detect_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// bench: bus and instruction sequences
// ------------------------------------------------
module fpu_exception_detect_tb_top;
    logic        clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwr = 1'h0, rdy, hresp;
    logic [1:0]  htr = 2'h0;
    logic [31:0] hadr = 32'h0, hwd = 32'h0, hrd, rd;
    logic        iv = 1'h0, rv = 1'h0, frs = 1'h0, fsame = 1'h0, mul = 1'h0;
    logic        ord = 1'h0, sa = 1'h0, sb = 1'h0, st, stl, tr, wb, ws;
    logic [3:0]  op = 4'h0;
    logic [2:0]  ca = 3'h1, cb = 3'h1, sel;
    logic [10:0] ea = 11'h400, eb = 11'h400;
    logic [8:0]  ih = 9'h000;
    logic [5:0]  rf = 6'h00, cs;
    logic [7:0]  traps;
    int          num_errors = 0, samples_checked = 0;

    initial forever #5 clk = ~clk;

    fed_exception_unit dut (.clk_sys_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
        .haddr_in(hadr), .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2),
        .hwdata_in(hwd), .hready_in(rdy), .hrdata_out(hrd), .hreadyout_out(rdy),
        .hresp_out(hresp), .issue_valid_in(iv), .issue_op_in(op),
        .issue_fmt_rsvd_in(frs), .issue_fmt_same_in(fsame), .issue_multi_in(mul),
        .issue_cmp_ordered_in(ord), .issue_a_class_in(ca), .issue_b_class_in(cb),
        .issue_a_sign_in(sa), .issue_b_sign_in(sb), .issue_a_exp_in(ea),
        .issue_b_exp_in(eb), .issue_int_hi_in(ih), .res_valid_in(rv),
        .res_inexact_in(rf[5]), .res_overflow_in(rf[4]), .res_tiny_in(rf[3]),
        .res_sign_in(rf[2]), .res_int_ovf_in(rf[1]), .res_long_range_in(rf[0]),
        .stall_req_out(st), .trap_req_out(tr), .wb_en_out(wb), .wb_sel_out(sel),
        .wb_sign_out(ws), .cause_out(cs));

    fed_cpu_model cpu (.clk_in(clk), .rst_n_in(rst_n), .trap_in(tr), .traps_out(traps));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one single word transfer; read data taken at the data phase edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htr <= 2'h2;
        hwr <= w;
        hadr <= {24'h0, a};
        do @(posedge clk); while (rdy !== 1'h1);
        hsel <= 1'h0;
        htr <= 2'h0;
        hwd <= d;
        do @(posedge clk); while (rdy !== 1'h1);
        rd = hrd;
    endtask : ahb

    // issue, then the result one cycle later
    task automatic run(input logic [3:0] o, input logic [2:0] a, input logic [5:0] f);
        @(posedge clk);
        iv <= 1'h1;
        op <= o;
        ca <= a;
        @(posedge clk);
        iv <= 1'h0;
        rv <= 1'h1;
        rf <= f;
        #1 stl = st;
        @(posedge clk);
        rv <= 1'h0;
        #1;
    endtask : run

    task automatic res(input string nm, input logic t, input logic w, input logic [2:0] s,
                       input logic [5:0] c);
        chk(nm, {tr, wb, cs}, {t, w, c});
        if (w)
            chk({nm, "_sel"}, sel, s);
    endtask : res

    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    initial begin
        #50000;
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        ahb(1'h0, fed_pkg::ADDR_CSR, 32'h0);
        chk("csr", rd, 32'h0);
        chk("resp", {rdy, hresp}, 32'h2);
        ahb(1'h0, 8'h08, 32'h0);
        chk("unmapped", rd, 32'h0);
        cb <= fed_pkg::CL_ZERO;
        run(fed_pkg::OP_DIV, fed_pkg::CL_NORM, 6'h00);
        chk("stall", stl, 32'h1);
        res("divz", 1'h0, 1'h1, 3'h2, 6'h08);
        ahb(1'h0, fed_pkg::ADDR_CSR, 32'h0);
        chk("csr", rd, 32'h0000_8020);
        ahb(1'h1, fed_pkg::ADDR_CSR, 32'h0000_0400);
        run(fed_pkg::OP_DIV, fed_pkg::CL_NORM, 6'h00);
        res("divz_t", 1'h1, 1'h0, 3'h0, 6'h08);
        ahb(1'h0, fed_pkg::ADDR_CSR, 32'h0);
        chk("csr", rd, 32'h0000_8400);
        cb <= fed_pkg::CL_NORM;
        ahb(1'h1, fed_pkg::ADDR_CSR, 32'h0000_0001);
        run(fed_pkg::OP_ADD, fed_pkg::CL_NORM, 6'h14);
        res("ovf", 1'h0, 1'h1, 3'h3, 6'h05);
        chk("ovf_sign", ws, 32'h1);
        ahb(1'h1, fed_pkg::ADDR_CSR, 32'h0);
        run(fed_pkg::OP_MUL, fed_pkg::CL_NORM, 6'h28);
        res("unf_fs0", 1'h1, 1'h0, 3'h0, 6'h20);
        ahb(1'h1, fed_pkg::ADDR_CSR, 32'h0100_0100);
        run(fed_pkg::OP_MUL, fed_pkg::CL_NORM, 6'h28);
        res("unf_uen", 1'h1, 1'h0, 3'h0, 6'h20);
        ahb(1'h1, fed_pkg::ADDR_CSR, 32'h0100_0002);
        run(fed_pkg::OP_MUL, fed_pkg::CL_NORM, 6'h28);
        res("unf_up_p", 1'h0, 1'h1, 3'h4, 6'h03);
        run(fed_pkg::OP_MUL, fed_pkg::CL_NORM, 6'h2C);
        res("unf_up_n", 1'h0, 1'h1, 3'h5, 6'h03);
        ahb(1'h1, fed_pkg::ADDR_CSR, 32'h0);
        run(fed_pkg::register_move_op, fed_pkg::CL_SNAN, 6'h00);
        res("mov_snan", 1'h0, 1'h1, 3'h0, 6'h00);
        run(fed_pkg::negate_op, fed_pkg::CL_SNAN, 6'h00);
        res("neg_snan", 1'h0, 1'h1, 3'h1, 6'h10);
        cb <= fed_pkg::CL_INF;
        run(fed_pkg::OP_MUL, fed_pkg::CL_ZERO, 6'h00);
        res("zero_inf", 1'h0, 1'h1, 3'h1, 6'h10);
        cb <= fed_pkg::CL_NORM;
        run(fed_pkg::OP_RSVD, fed_pkg::CL_NORM, 6'h00);
        res("rsvd", 1'h1, 1'h0, 3'h0, 6'h20);
        ih <= 9'h1FF;
        run(fed_pkg::OP_L2F, fed_pkg::CL_NORM, 6'h00);
        res("l2f_ok", 1'h0, 1'h1, 3'h0, 6'h00);
        ih <= 9'h100;
        run(fed_pkg::OP_L2F, fed_pkg::CL_NORM, 6'h00);
        res("l2f_bad", 1'h1, 1'h0, 3'h0, 6'h20);
        ord <= 1'h1;
        run(fed_pkg::OP_CMP, fed_pkg::CL_QNAN, 6'h00);
        res("cmp_unord", 1'h0, 1'h1, 3'h1, 6'h10);
        run(fed_pkg::OP_ADD, fed_pkg::CL_DENORM, 6'h00);
        res("add_den", 1'h1, 1'h0, 3'h0, 6'h20);
        run(fed_pkg::OP_F2W, fed_pkg::CL_NORM, 6'h02);
        res("f2w_ovf", 1'h1, 1'h0, 3'h0, 6'h20);
        mul <= 1'h1;
        run(fed_pkg::OP_ADD, fed_pkg::CL_NORM, 6'h00);
        chk("stall_off", stl, 32'h0);
        ahb(1'h1, fed_pkg::ADDR_CSR, 32'h0000_0080);
        run(fed_pkg::OP_ADD, fed_pkg::CL_NORM, 6'h00);
        chk("stall_ien", stl, 32'h1);
        ahb(1'h1, fed_pkg::ADDR_CSR, 32'h0);
        mul <= 1'h0;
        ea <= 11'h7F0;
        run(fed_pkg::OP_ADD, fed_pkg::CL_NORM, 6'h00);
        chk("stall_exp", stl, 32'h1);
        @(posedge clk);
        iv <= 1'h1;
        op <= fed_pkg::OP_DIV;
        cb <= fed_pkg::CL_ZERO;
        @(posedge clk);
        iv <= 1'h0;
        ahb(1'h0, fed_pkg::ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h0000_0108);
        chk("traps", traps, 32'h7);
        finish_test();
    end
endmodule : fpu_exception_detect_tb_top
`default_nettype wire
